// *** obld_acc_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// access decision carrier
// ---------------------------------------------------------------
interface obld_acc_if;
   import obld_pkg::*;
   obld_op_t   op;
   obld_area_t area;
   logic       prog_lock_n;
   logic       data_lock_n;
   logic       allow;

   modport checker_mp (input op, area, prog_lock_n, data_lock_n, output allow);
   modport user_mp    (output op, area, prog_lock_n, data_lock_n, input allow);
endinterface

`default_nettype wire

// *** obld_lock_check.sv ***
`timescale 1ns/100ps
`default_nettype none

module obld_lock_check (
   obld_acc_if.checker_mp acc   // decision request and answer
);
   import obld_pkg::*;

   // ---------------------------------------------------------------
   // lock decision table
   // ---------------------------------------------------------------
   // configuration bytes need both locks open; bank erase too
   always_comb begin
      acc.allow = 1'b0;
      case (acc.area)
         OBLD_AREA_PROG: begin
            // any program area access refused once locked [R10] [R13] [R14]
            acc.allow = acc.prog_lock_n && (acc.op != OBLD_OP_RSVD);
         end
         OBLD_AREA_DATA: begin
            // data area refused once locked [R11] [R14]
            acc.allow = acc.data_lock_n && (acc.op != OBLD_OP_RSVD);
         end
         OBLD_AREA_CFG: begin
            acc.allow = acc.prog_lock_n && acc.data_lock_n && (acc.op != OBLD_OP_RSVD);
         end
         default: begin
            acc.allow = 1'b0;
         end
      endcase
      // bank erase wipes everything, so only with both open [R12] [R13]
      if (acc.op == OBLD_OP_BANK_ERASE) begin
         acc.allow = acc.prog_lock_n && acc.data_lock_n;
      end
   end

endmodule

`default_nettype wire

// *** obld_nvm_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// nonvolatile byte store behind the power up loader
// ---------------------------------------------------------------
module obld_nvm_model (
   input  wire  logic                             clk,         // system clock
   input  wire  logic                             rst_n,       // power up reset
   input  wire  logic                             nvm_rd_req,  // loader fetch request
   input  wire  logic                             nvm_rd_idx,  // 0 option, 1 lock
   output logic                                   nvm_rd_ack,  // fetch data valid pulse
   output logic [obld_pkg::OBLD_BYTE_W-1:0]       nvm_rd_data, // fetched byte
   input  wire  logic [obld_pkg::OBLD_BYTE_W-1:0] opt_byte,    // stored option byte
   input  wire  logic [obld_pkg::OBLD_BYTE_W-1:0] lock_byte,   // stored lock byte
   input  var   int                               delay        // idle cycles before an ack
);
   int                             wait_cnt;
   logic [obld_pkg::OBLD_BYTE_W-1:0] last;

   initial begin
      nvm_rd_ack  = 1'b0;
      nvm_rd_data = 8'h00;
      wait_cnt    = 0;
      last        = 8'h00;
   end

   // one ack per fetch; between acks the data line shows the inverse
   // of the last byte so a loader sampling late never sees a match
   always @(posedge clk) begin
      #1;
      if (!rst_n) begin
         wait_cnt    = 0;
         nvm_rd_ack  = 1'b0;
         nvm_rd_data = ~last;
      end else if (nvm_rd_req && !nvm_rd_ack && wait_cnt >= delay) begin
         nvm_rd_ack  = 1'b1;
         nvm_rd_data = nvm_rd_idx ? lock_byte : opt_byte;
         last        = nvm_rd_data;
         wait_cnt    = 0;
      end else begin
         nvm_rd_ack  = 1'b0;
         nvm_rd_data = ~last;
         if (nvm_rd_req) begin
            wait_cnt = wait_cnt + 1;
         end
      end
   end
endmodule

`default_nettype wire

// *** obld_pkg.sv ***
package obld_pkg;

   // ---------------------------------------------------------------
   // byte layout
   // ---------------------------------------------------------------
   localparam int OBLD_BYTE_W = 8;
   localparam int OBLD_ADDR_W = 16;

   // device option byte bit positions
   localparam int OBLD_OPT_WDT_CLK_BIT  = 7;
   localparam int OBLD_OPT_RST_PIN_BIT  = 6;
   localparam int OBLD_OPT_PORT_LVL_BIT = 5;
   localparam int OBLD_OPT_BOD_BIT      = 4;
   localparam int OBLD_OPT_FIXED_BIT    = 3;
   localparam int OBLD_OPT_FILTER_BIT   = 2;
   localparam int OBLD_OPT_OSC_HI_BIT   = 1;
   localparam int OBLD_OPT_OSC_LO_BIT   = 0;

   // security lock byte bit positions, zero means locked
   localparam int OBLD_LOCK_PROG_BIT = 7;
   localparam int OBLD_LOCK_DATA_BIT = 6;

   // live lock pair layout
   localparam int OBLD_LIVE_PROG = 1;
   localparam int OBLD_LIVE_DATA = 0;
   localparam logic [1:0] OBLD_LIVE_OPEN = 2'h3;

   // erased flash reads as all ones
   localparam logic [OBLD_BYTE_W-1:0] OBLD_ERASED_BYTE = 8'hFF;
   localparam logic [OBLD_BYTE_W-1:0] OBLD_ZERO_BYTE   = 8'h00;

   // data move addresses of the two bytes
   localparam logic [OBLD_ADDR_W-1:0] OBLD_OPT_ADDR  = 16'hFFF0;
   localparam logic [OBLD_ADDR_W-1:0] OBLD_LOCK_ADDR = 16'hFFF1;

   // nonvolatile byte index
   localparam logic OBLD_NVM_OPT_IDX  = 1'b0;
   localparam logic OBLD_NVM_LOCK_IDX = 1'b1;

   // ---------------------------------------------------------------
   // enumerations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OBLD_OSC_XTAL_FAST = 2'h0,   // 4 to 12 MHz crystal
      OBLD_OSC_RC_455K   = 2'h1,   // internal 455KHz rc
      OBLD_OSC_XTAL_SLOW = 2'h2,   // 32KHz to 1MHz crystal
      OBLD_OSC_EXT_CLK   = 2'h3    // external clock on crystal input
   } obld_osc_t;

   typedef enum logic [1:0] {
      OBLD_OP_READ       = 2'h0,
      OBLD_OP_PROGRAM    = 2'h1,
      OBLD_OP_BANK_ERASE = 2'h2,
      OBLD_OP_RSVD       = 2'h3
   } obld_op_t;

   typedef enum logic [1:0] {
      OBLD_AREA_PROG = 2'h0,
      OBLD_AREA_DATA = 2'h1,
      OBLD_AREA_CFG  = 2'h2,
      OBLD_AREA_RSVD = 2'h3
   } obld_area_t;

   typedef enum logic [2:0] {
      OBLD_ST_LOAD_OPT  = 3'h1,
      OBLD_ST_LOAD_LOCK = 3'h2,
      OBLD_ST_READY     = 3'h4
   } obld_state_t;

endpackage

// *** obld_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import obld_pkg::*;
   logic       clk, rst_n, nvm_rd_req, nvm_rd_idx, nvm_rd_ack, cpu_rd_strobe, cpu_rd_valid;
   logic       tool_req, tool_cfg_idx, tool_grant, tool_deny, cfg_ready, loaded;
   logic       watchdog_clock_select, reset_pin_disable, port_reset_level;
   logic       brownout_level_select, osc_filter_enable;
   logic [7:0] nvm_rd_data, cpu_rd_data, tool_wdata, tool_rdata, opt_b, lock_b, opt_seen;
   logic [15:0] cpu_rd_addr;
   logic [1:0] live;
   obld_op_t   tool_op;
   obld_area_t tool_area;
   obld_osc_t  osc_type;
   int         failures, total_checks, dly;
   logic [7:0] opts [4] = '{8'hA8, 8'h5D, 8'hEE, 8'h1B};
   logic [7:0] locks [4] = '{8'hFF, 8'h7F, 8'h3F, 8'hBF};
   int         dlys [4] = '{0, 3, 1, 2};

   // option outputs gathered back into byte order, fixed bit 3 as one
   assign opt_seen = {watchdog_clock_select, reset_pin_disable, port_reset_level,
                      brownout_level_select, 1'b1, osc_filter_enable, osc_type};

   obld_top i_obld_top (.clk(clk), .rst_n(rst_n), .nvm_rd_req(nvm_rd_req),
      .nvm_rd_idx(nvm_rd_idx), .nvm_rd_ack(nvm_rd_ack), .nvm_rd_data(nvm_rd_data),
      .cpu_rd_strobe(cpu_rd_strobe), .cpu_rd_addr(cpu_rd_addr), .cpu_rd_valid(cpu_rd_valid),
      .cpu_rd_data(cpu_rd_data), .tool_req(tool_req), .tool_op(tool_op),
      .tool_area(tool_area), .tool_cfg_idx(tool_cfg_idx), .tool_wdata(tool_wdata),
      .tool_grant(tool_grant), .tool_deny(tool_deny), .tool_rdata(tool_rdata),
      .cfg_ready(cfg_ready), .watchdog_clock_select(watchdog_clock_select),
      .reset_pin_disable(reset_pin_disable), .port_reset_level(port_reset_level),
      .brownout_level_select(brownout_level_select), .osc_filter_enable(osc_filter_enable),
      .osc_type(osc_type));

   obld_nvm_model i_obld_nvm_model (.clk(clk), .rst_n(rst_n), .nvm_rd_req(nvm_rd_req),
      .nvm_rd_idx(nvm_rd_idx), .nvm_rd_ack(nvm_rd_ack), .nvm_rd_data(nvm_rd_data),
      .opt_byte(opt_b), .lock_byte(lock_b), .delay(dly));

   // ---------------------------------------------------------------
   // clock, checking and closing
   // ---------------------------------------------------------------
   always #5 clk = ~clk;

   task check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task close_out;
      if (failures == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   // data move read; answer looked at in the single cycle it stands
   task cpu_read(input logic [15:0] a, input logic [7:0] exp, input logic hit);
      cpu_rd_strobe = 1'b1;
      cpu_rd_addr   = a;
      @(posedge clk);
      #1;
      cpu_rd_strobe = 1'b0;
      check(8'(cpu_rd_valid), 8'(hit));
      check(cpu_rd_data, hit ? exp : 8'h00);
      @(posedge clk);
      #1;
   endtask

   // tool request; the bench keeps its own copy of the live locks
   task tool(input obld_op_t op, input obld_area_t ar, input logic idx, input logic [7:0] wd);
      logic       g;
      logic [7:0] rd;
      if (!loaded || op == OBLD_OP_RSVD) g = 1'b0;
      else if (op == OBLD_OP_BANK_ERASE) g = &live;
      else if (ar == OBLD_AREA_RSVD) g = 1'b0;
      else if (ar == OBLD_AREA_PROG) g = live[1];
      else if (ar == OBLD_AREA_DATA) g = live[0];
      else g = &live;
      rd = (g && op == OBLD_OP_READ && ar == OBLD_AREA_CFG) ? (idx ? lock_b : opt_b) : 8'h00;
      tool_req     = 1'b1;
      tool_op      = op;
      tool_area    = ar;
      tool_cfg_idx = idx;
      tool_wdata   = wd;
      @(posedge clk);
      #1;
      tool_req = 1'b0;
      check(8'(tool_grant), 8'(g));
      check(8'(tool_deny), 8'(!g));
      check(tool_rdata, rd);
      if (g && op == OBLD_OP_PROGRAM && ar == OBLD_AREA_CFG && idx) live = live & wd[7:6];
      if (g && op == OBLD_OP_BANK_ERASE) live = 2'h3;
      @(posedge clk);
      #1;
   endtask

   // power cycle with new stored bytes, then confirm what was latched
   task power(input logic [7:0] o, input logic [7:0] l, input int d);
      int n;
      rst_n  = 1'b0;
      opt_b  = o;
      lock_b = l;
      dly    = d;
      loaded = 1'b0;
      live   = l[7:6];
      repeat (8) @(posedge clk);
      #1;
      check(opt_seen, 8'hFF);
      check(8'(cfg_ready), 8'h00);
      rst_n = 1'b1;
      tool(OBLD_OP_READ, OBLD_AREA_DATA, 1'b0, 8'h00);
      n = 0;
      while (cfg_ready !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1;
         n = n + 1;
      end
      loaded = 1'b1;
      check(8'(cfg_ready), 8'h01);
      check(opt_seen, o);
      cpu_read(OBLD_OPT_ADDR, o, 1'b1);
      cpu_read(OBLD_LOCK_ADDR, l, 1'b1);
      cpu_read(16'hFFF2, 8'h00, 1'b0);
   endtask

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0; rst_n = 1'b0; tool_req = 1'b0; tool_op = OBLD_OP_READ;
      tool_area = OBLD_AREA_PROG; tool_cfg_idx = 1'b0; tool_wdata = 8'h00;
      cpu_rd_strobe = 1'b0; cpu_rd_addr = 16'h0000; failures = 0; total_checks = 0;
      loaded = 1'b0; live = 2'h3; opt_b = 8'hFF; lock_b = 8'hFF; dly = 0;
      for (int p = 0; p < 4; p++) begin
         power(opts[p], locks[p], dlys[p]);
         // every op against every area, reserved codes included
         for (int o = 0; o < 4; o++) begin
            for (int a = 0; a < 4; a++) begin
               tool(obld_op_t'(o[1:0]), obld_area_t'(a[1:0]), o[0], 8'hFF);
            end
         end
         if (p == 0) begin
            tool(OBLD_OP_READ, OBLD_AREA_CFG, 1'b1, 8'h00);
            tool(OBLD_OP_PROGRAM, OBLD_AREA_CFG, 1'b0, 8'h00);
            check(opt_seen, opts[0]);
            tool(OBLD_OP_PROGRAM, OBLD_AREA_CFG, 1'b1, 8'h7F);
            tool(OBLD_OP_READ, OBLD_AREA_PROG, 1'b0, 8'h00);
            tool(OBLD_OP_PROGRAM, OBLD_AREA_DATA, 1'b0, 8'h00);
            tool(OBLD_OP_BANK_ERASE, OBLD_AREA_PROG, 1'b0, 8'h00);
            tool(OBLD_OP_READ, OBLD_AREA_CFG, 1'b1, 8'h00);
            cpu_read(OBLD_LOCK_ADDR, locks[0], 1'b1);
         end
      end
      close_out;
   end

   // watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #200000;
      failures = failures + 1;
      close_out;
   end
endmodule

`default_nettype wire

// *** obld_top.sv ***
`timescale 1ns/100ps
`default_nettype none

// How it works
// (R01) options latched from flash at power up; program cannot change them later
// (R02) data move reads at the two addresses return the latched bytes
// (R03) option bit 7: zero internal 20KHz rc watchdog clock, one cpu clock
// (R04) option bit 6: zero keeps reset pin, one makes it a plain input
// (R05) option bit 5: port pins reset low on zero, high on one
// (R06) option bit 4: brownout threshold 3.8V on zero, 2.5V on one
// (R07) programmer always writes option bit 3 as one
// (R08) option bit 2: zero disables oscillator filter, one enables it
// (R09) option bits 1..0 pick crystal, 455KHz rc, slow crystal or external clock
// (R10) program lock zero refuses program area and configuration access
// (R11) data lock zero refuses data area and configuration access
// (R12) both locks one: tool may erase, program and read both areas
// (R13) program locked only: code reads blocked, data usable, bank erase ignored
// (R14) both locks zero: tool reads of both areas blocked
// (R15) programmer sets a lock only after programming and verifying
// (R16) tool erases and writes configuration in one unbroken sequence
// (R17) flash is blank from the factory and must be loaded first

module obld_top (
   input  wire  logic                         clk,                   // 100 MHz clock
   input  wire  logic                         rst_n,                 // power up reset
   output logic                               nvm_rd_req,            // byte fetch request
   output logic                               nvm_rd_idx,            // byte index, 0 option
   input  wire  logic                         nvm_rd_ack,            // fetch data valid
   input  wire  logic [obld_pkg::OBLD_BYTE_W-1:0] nvm_rd_data,       // fetched byte
   input  wire  logic                         cpu_rd_strobe,         // data move read
   input  wire  logic [obld_pkg::OBLD_ADDR_W-1:0] cpu_rd_addr,       // data move address
   output logic                               cpu_rd_valid,          // read hit pulse
   output logic [obld_pkg::OBLD_BYTE_W-1:0]   cpu_rd_data,           // read data
   input  wire  logic                         tool_req,              // tool request pulse
   input  wire  obld_pkg::obld_op_t           tool_op,               // tool operation
   input  wire  obld_pkg::obld_area_t         tool_area,             // tool target area
   input  wire  logic                         tool_cfg_idx,          // which config byte
   input  wire  logic [obld_pkg::OBLD_BYTE_W-1:0] tool_wdata,        // tool write byte
   output logic                               tool_grant,            // access allowed pulse
   output logic                               tool_deny,             // access refused pulse
   output logic [obld_pkg::OBLD_BYTE_W-1:0]   tool_rdata,            // config read data
   output logic                               cfg_ready,             // options valid
   output logic                               watchdog_clock_select, // 1 cpu clock
   output logic                               reset_pin_disable,     // 1 pin is input
   output logic                               port_reset_level,      // 1 ports reset high
   output logic                               brownout_level_select, // 1 low threshold
   output logic                               osc_filter_enable,     // 1 filter on
   output obld_pkg::obld_osc_t                osc_type               // clock source
);
   import obld_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   obld_state_t                state;
   obld_state_t                next_state;
   logic [OBLD_BYTE_W-1:0]     device_option_byte;
   logic [OBLD_BYTE_W-1:0]     security_lock_byte;
   logic [1:0]                 lock_live;
   logic                       take_req;
   logic                       cfg_write;

   obld_acc_if acc ();

   // ---------------------------------------------------------------
   // power up loader
   // ---------------------------------------------------------------
   // one fetch per byte, then parked until the next power up
   always_comb begin
      next_state = state;
      case (state)
         OBLD_ST_LOAD_OPT: begin
            if (nvm_rd_ack) begin
               next_state = OBLD_ST_LOAD_LOCK;
            end
         end
         OBLD_ST_LOAD_LOCK: begin
            if (nvm_rd_ack) begin
               next_state = OBLD_ST_READY;
            end
         end
         OBLD_ST_READY: begin
            next_state = OBLD_ST_READY;
         end
         default: begin
            next_state = OBLD_ST_LOAD_OPT;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= OBLD_ST_LOAD_OPT;
      end else begin
         state <= next_state;
      end
   end

   // fetch index follows the loader, held in a flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nvm_rd_idx <= OBLD_NVM_OPT_IDX;
      end else if (state == OBLD_ST_LOAD_OPT && nvm_rd_ack) begin
         nvm_rd_idx <= OBLD_NVM_LOCK_IDX;
      end
   end

   assign nvm_rd_req = (state == OBLD_ST_LOAD_OPT) || (state == OBLD_ST_LOAD_LOCK);
   assign cfg_ready  = (state == OBLD_ST_READY);

   // ---------------------------------------------------------------
   // latched bytes
   // ---------------------------------------------------------------
   // no write path from software exists; only a power up reloads [R01]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         device_option_byte <= OBLD_ERASED_BYTE;
      end else if (state == OBLD_ST_LOAD_OPT && nvm_rd_ack) begin
         device_option_byte <= nvm_rd_data;   // [R01]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         security_lock_byte <= OBLD_ERASED_BYTE;
      end else if (state == OBLD_ST_LOAD_LOCK && nvm_rd_ack) begin
         security_lock_byte <= nvm_rd_data;   // [R01]
      end
   end

   // ---------------------------------------------------------------
   // decoded options
   // ---------------------------------------------------------------
   // bit 3 is taken as written by the programmer and not decoded [R07]
   assign watchdog_clock_select = device_option_byte[OBLD_OPT_WDT_CLK_BIT];   // [R03]
   assign reset_pin_disable     = device_option_byte[OBLD_OPT_RST_PIN_BIT];   // [R04]
   assign port_reset_level      = device_option_byte[OBLD_OPT_PORT_LVL_BIT];  // [R05]
   assign brownout_level_select = device_option_byte[OBLD_OPT_BOD_BIT];       // [R06]
   assign osc_filter_enable     = device_option_byte[OBLD_OPT_FILTER_BIT];    // [R08]
   assign osc_type = obld_osc_t'({device_option_byte[OBLD_OPT_OSC_HI_BIT],
                                  device_option_byte[OBLD_OPT_OSC_LO_BIT]});  // [R09]

   // ---------------------------------------------------------------
   // data move read port
   // ---------------------------------------------------------------
   // unmapped addresses give no valid and zero data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_rd_valid <= 1'b0;
         cpu_rd_data  <= OBLD_ZERO_BYTE;
      end else begin
         cpu_rd_valid <= 1'b0;
         cpu_rd_data  <= OBLD_ZERO_BYTE;
         if (cpu_rd_strobe && cpu_rd_addr == OBLD_OPT_ADDR) begin
            cpu_rd_valid <= 1'b1;
            cpu_rd_data  <= device_option_byte;   // [R02]
         end else if (cpu_rd_strobe && cpu_rd_addr == OBLD_LOCK_ADDR) begin
            cpu_rd_valid <= 1'b1;
            cpu_rd_data  <= security_lock_byte;   // [R02]
         end
      end
   end

   // ---------------------------------------------------------------
   // live locks
   // ---------------------------------------------------------------
   // a lock written by the tool bites at once, not at next power up
   assign take_req  = tool_req && cfg_ready;
   assign cfg_write = take_req && acc.allow && tool_op == OBLD_OP_PROGRAM
                      && tool_area == OBLD_AREA_CFG && tool_cfg_idx == OBLD_NVM_LOCK_IDX;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_live <= OBLD_LIVE_OPEN;
      end else if (state == OBLD_ST_LOAD_LOCK && nvm_rd_ack) begin
         lock_live <= {nvm_rd_data[OBLD_LOCK_PROG_BIT], nvm_rd_data[OBLD_LOCK_DATA_BIT]};
      end else if (cfg_write) begin
         // programming only clears flash bits, so locks only tighten [R10] [R11]
         lock_live <= lock_live & {tool_wdata[OBLD_LOCK_PROG_BIT],
                                   tool_wdata[OBLD_LOCK_DATA_BIT]};
      end else if (take_req && acc.allow && tool_op == OBLD_OP_BANK_ERASE) begin
         lock_live <= OBLD_LIVE_OPEN;   // [R12]
      end
   end

   // ---------------------------------------------------------------
   // tool access port
   // ---------------------------------------------------------------
   assign acc.op          = tool_op;
   assign acc.area        = tool_area;
   assign acc.prog_lock_n = lock_live[OBLD_LIVE_PROG];
   assign acc.data_lock_n = lock_live[OBLD_LIVE_DATA];

   obld_lock_check u_check (
      .acc (acc.checker_mp)
   );

   // requests before the locks are known are refused, never guessed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tool_grant <= 1'b0;
         tool_deny  <= 1'b0;
         tool_rdata <= OBLD_ZERO_BYTE;
      end else begin
         tool_grant <= take_req && acc.allow;          // [R12]
         tool_deny  <= tool_req && !(cfg_ready && acc.allow);   // [R10] [R11] [R14]
         tool_rdata <= OBLD_ZERO_BYTE;
         if (take_req && acc.allow && tool_op == OBLD_OP_READ && tool_area == OBLD_AREA_CFG) begin
            tool_rdata <= (tool_cfg_idx == OBLD_NVM_LOCK_IDX) ? security_lock_byte
                                                              : device_option_byte;
         end
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   opt_frozen_a: assert property (cfg_ready && $past(cfg_ready)   // [R01]
      |-> $stable(device_option_byte) && $stable(osc_type))
      else $error("option byte changed while running");

   cpu_rd_opt_a: assert property (cpu_rd_strobe && cpu_rd_addr == OBLD_OPT_ADDR   // [R02]
      |=> cpu_rd_valid && cpu_rd_data == $past(device_option_byte))
      else $error("option byte read wrong");

   wdt_clk_a: assert property (state == OBLD_ST_LOAD_OPT && nvm_rd_ack   // [R03]
      |=> watchdog_clock_select == $past(nvm_rd_data[OBLD_OPT_WDT_CLK_BIT]))
      else $error("watchdog clock select not from bit 7");

   rst_pin_a: assert property (state == OBLD_ST_LOAD_OPT && nvm_rd_ack   // [R04]
      |=> reset_pin_disable == $past(nvm_rd_data[OBLD_OPT_RST_PIN_BIT])
          && port_reset_level == $past(nvm_rd_data[OBLD_OPT_PORT_LVL_BIT]))   // [R05]
      else $error("reset pin or port level wrong");

   bod_osc_a: assert property (state == OBLD_ST_LOAD_OPT && nvm_rd_ack   // [R06]
      |=> brownout_level_select == $past(nvm_rd_data[OBLD_OPT_BOD_BIT])
          && osc_filter_enable == $past(nvm_rd_data[OBLD_OPT_FILTER_BIT])   // [R08]
          && osc_type == $past(nvm_rd_data[OBLD_OPT_OSC_HI_BIT:OBLD_OPT_OSC_LO_BIT]))  // [R09]
      else $error("brownout, filter or oscillator select wrong");

   prog_lock_a: assert property (tool_req && !lock_live[OBLD_LIVE_PROG]   // [R10]
      && tool_area != OBLD_AREA_DATA |=> tool_deny && !tool_grant)
      else $error("program lock not enforced");

   data_lock_a: assert property (tool_req && !lock_live[OBLD_LIVE_DATA]   // [R11]
      && tool_area != OBLD_AREA_PROG |=> tool_deny && !tool_grant)
      else $error("data lock not enforced");

   open_grant_a: assert property (tool_req && cfg_ready && lock_live == OBLD_LIVE_OPEN   // [R12]
      && tool_op != OBLD_OP_RSVD && tool_area != OBLD_AREA_RSVD |=> tool_grant && !tool_deny)
      else $error("open device refused access");

   code_lock_a: assert property (tool_req && cfg_ready && !lock_live[OBLD_LIVE_PROG]   // [R13]
      && lock_live[OBLD_LIVE_DATA] && tool_area == OBLD_AREA_DATA
      && (tool_op == OBLD_OP_READ || tool_op == OBLD_OP_PROGRAM) |=> tool_grant)
      else $error("data area refused with only code locked");

   bank_erase_a: assert property (tool_req && !lock_live[OBLD_LIVE_PROG]   // [R13]
      && tool_op == OBLD_OP_BANK_ERASE |=> tool_deny ##1 !lock_live[OBLD_LIVE_PROG])
      else $error("bank erase acted under code lock");

   both_lock_a: assert property (tool_req && lock_live == 2'h0   // [R14]
      && tool_op == OBLD_OP_READ |=> !tool_grant [*2])
      else $error("read allowed with both locks");

   load_bound_a: assert property ($rose(cfg_ready) |-> $past(nvm_rd_ack)   // [R01]
      && $past(nvm_rd_idx) == OBLD_NVM_LOCK_IDX)
      else $error("ready without lock byte fetch");

   one_answer_a: assert property (tool_req |=> tool_grant != tool_deny)   // [R12]
      else $error("tool request without exactly one answer");

   early_deny_a: assert property (tool_req && !cfg_ready   // [R01]
      |=> tool_deny && !tool_grant)
      else $error("tool request granted before load");

   rsvd_op_a: assert property (tool_req && tool_op == OBLD_OP_RSVD   // [R12]
      |=> tool_deny && !tool_grant)
      else $error("reserved operation granted");

   cpu_rd_lock_a: assert property (cpu_rd_strobe && cpu_rd_addr == OBLD_LOCK_ADDR   // [R02]
      |=> cpu_rd_valid && cpu_rd_data == $past(security_lock_byte))
      else $error("lock byte read wrong");

   cpu_rd_miss_a: assert property (cpu_rd_strobe && cpu_rd_addr != OBLD_OPT_ADDR   // [R02]
      && cpu_rd_addr != OBLD_LOCK_ADDR |=> !cpu_rd_valid && cpu_rd_data == OBLD_ZERO_BYTE)
      else $error("unmapped read answered");

   // a programmed lock byte may only clear live lock bits, never set them
   lock_tight_a: assert property (cfg_write   // [R10] [R11]
      |=> (lock_live | $past(lock_live)) == $past(lock_live))
      else $error("lock programming loosened a lock");

   // main scenarios; each tool request is answered in the next cycle, every cycle if asked
   load_done_c:  cover property ($rose(cfg_ready));
   cpu_read_c:   cover property (cpu_rd_valid && cfg_ready);
   tool_grant_c: cover property (tool_grant);
   lock_set_c:   cover property (cfg_write ##2 tool_req ##1 tool_deny);

endmodule

`default_nettype wire
